// ---- design/tmc_pkg.sv ----
// Constants, register map and carrier types of the timer modulo and channel block.
// Assumes one APB slave port with 32-bit data, one clock and an active-low reset.
package tmc_pkg;

    // ************************************************************
    // Register map (byte addresses, one word per register)
    // ************************************************************
    localparam logic [7:0] TMC_CTRL_OFS = 8'h00;    // Run, center select, overflow
    localparam logic [7:0] TMC_COUNT_OFS = 8'h04;   // Counter read, write clears
    localparam logic [7:0] TMC_LIM_HI_OFS = 8'h08;  // count_limit_high
    localparam logic [7:0] TMC_LIM_LO_OFS = 8'h0C;  // count_limit_low
    localparam logic [7:0] TMC_CH_BASE = 8'h10;     // channel_status_control of channel 0
    localparam logic [7:0] TMC_CH_STRIDE = 8'h08;   // Spacing between channels
    localparam logic [7:0] TMC_CH_VAL_OFS = 8'h04;  // Channel value after status word

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int TMC_FLAG_BIT = 7;   // channel_event_flag and overflow_flag
    localparam int TMC_IE_BIT = 6;     // channel_irq_enable and overflow enable
    localparam int TMC_MSB_BIT = 5;    // channel_mode_select_b
    localparam int TMC_MSA_BIT = 4;    // channel_mode_select_a
    localparam int TMC_ELS_HI_BIT = 3; // edge_level_select_high
    localparam int TMC_ELS_LO_BIT = 2; // edge_level_select_low
    localparam int TMC_CPWM_BIT = 5;   // center_align_select in control word
    localparam int TMC_RUN_BIT = 0;    // Counter run enable in control word

    // ************************************************************
    // Values
    // ************************************************************
    localparam logic [15:0] TMC_LIM_RST = 16'h0000;  // Limit after reset
    localparam logic [15:0] TMC_CNT_ZERO = 16'h0000; // Counter restart value
    localparam logic [15:0] TMC_CNT_MAX = 16'hFFFF;  // Terminal count when free running
    localparam logic [15:0] TMC_CNT_STEP = 16'h0001; // Counter step
    localparam logic [1:0] TMC_ELS_OFF = 2'b00;      // Pin detached
    localparam logic [1:0] TMC_ELS_TOGGLE = 2'b01;   // Compare toggles
    localparam logic [1:0] TMC_ELS_CLR = 2'b10;      // Compare drives low
    localparam logic [1:0] TMC_ELS_SET = 2'b11;      // Compare drives high
    localparam logic [1:0] TMC_PEND_NONE = 2'b00;    // No limit byte waiting
    localparam logic [1:0] TMC_PEND_LO = 2'b01;      // Low byte written, high awaited
    localparam logic [1:0] TMC_PEND_HI = 2'b10;      // High byte written, low awaited
    localparam int TMC_NUM_CH = 2;                   // Default channel count

    // Channel operating modes, Gray coded
    typedef enum logic [1:0] {
        TMC_MODE_IC = 2'b00,
        TMC_MODE_OC = 2'b01,
        TMC_MODE_EPWM = 2'b11,
        TMC_MODE_CPWM = 2'b10
    } tmc_mode_t;

    // APB request carrier, field names as published
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } tmc_apb_req_t;

    // Per-channel state
    typedef struct packed {
        logic flag;        // channel_event_flag
        logic ie;          // channel_irq_enable
        logic msb;         // channel_mode_select_b
        logic msa;         // channel_mode_select_a
        logic [1:0] els;   // edge_level_select_high:low
        logic [15:0] val;  // Channel value
        logic pin;         // Driven pin level
        logic prev;        // Last pin sample for edge detection
        logic armed;       // Flag was read set, clear may follow
    } tmc_ch_t;

endpackage

// ---- design/tmc_timer.sv ----
// Timer modulo counter with per-channel capture, compare and PWM.
// Assumes channel pins sampled on pclk, pad logic outside, APB master.
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ns
module tmc_timer #(
    parameter int NUM_CH = tmc_pkg::TMC_NUM_CH  // Number of channels
) (
    input wire logic pclk,                      // Clock, 20 MHz
    input wire logic presetn,                   // Asynchronous reset, active low
    input tmc_pkg::tmc_apb_req_t apb_req,       // APB request
    output logic [31:0] prdata,                 // APB read data
    output logic pready,                        // APB ready
    output logic pslverr,                       // APB error on unmapped address
    input wire logic [NUM_CH-1:0] ch_in,        // Channel pin levels
    output logic [NUM_CH-1:0] ch_out,           // Channel pin drive levels
    output logic [NUM_CH-1:0] ch_oe_n,          // Pin drive enable, low drives
    output logic [NUM_CH-1:0] ch_irq,           // Channel interrupt requests
    output logic ovf_irq                        // Overflow interrupt request
);
    import tmc_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [15:0] cnt;        // Main counter
        logic down;              // Counting down in center mode
        logic [15:0] lim;        // count_limit_high:low
        logic [1:0] lim_pend;    // Which limit byte awaits its partner
        logic run;               // Counter enable
        logic cpwm;              // center_align_select
        logic ovie;              // Overflow interrupt enable
        logic ovf;               // overflow_flag
        logic ovf_armed;         // Overflow flag read while set
        logic ready;             // APB wait state done
        logic slverr;            // Registered error answer
        logic [31:0] rdata;      // Registered read data
        tmc_ch_t [NUM_CH-1:0] ch;
    } tmc_state_t;

    tmc_state_t s_q;             // Registered state
    tmc_state_t s_d;             // Next state

    logic acc;                   // Access phase present
    logic done;                  // Access completes this edge
    logic wr;                    // Completing write
    logic rd;                    // Completing read
    logic [15:0] term;           // Effective terminal count
    logic inhibit;               // Limit half written
    logic wrap;                  // Counter reached its end of period
    logic ovf_ev;                // Overflow flag set event
    logic [31:0] rdat;           // Read mux
    logic err;                   // Unmapped address
    logic [NUM_CH-1:0] ev_v;     // Channel events this cycle
    logic [NUM_CH-1:0] used_v;   // Pin attached and driven
    tmc_mode_t mode;             // Mode of the channel being worked on
    logic rise;                  // Rising edge on pin
    logic fall;                  // Falling edge on pin
    logic match;                 // Counter equals channel value
    logic [7:0] sc_a;            // Status address of channel
    logic [7:0] val_a;           // Value address of channel
    logic [NUM_CH-1:0] flags_v;  // Channel flags, seen by the checks

    // ************************************************************
    // Next-state logic
    // ************************************************************
    // Whole block in one pass: counter, channels, then register writes
    always_comb begin
        s_d = s_q;
        acc = apb_req.psel & apb_req.penable;
        done = acc & s_q.ready;
        wr = done & apb_req.pwrite;
        rd = done & ~apb_req.pwrite;
        // One wait state gives registered read data
        s_d.ready = acc & ~s_q.ready;
        // Zero limit runs the full 16-bit range
        term = (s_q.lim == TMC_LIM_RST) ? TMC_CNT_MAX : s_q.lim;
        inhibit = s_q.lim_pend != TMC_PEND_NONE;
        wrap = 1'b0;
        rdat = '0;
        err = 1'b1;
        ev_v = '0;
        used_v = '0;
        mode = TMC_MODE_IC;
        rise = 1'b0;
        fall = 1'b0;
        match = 1'b0;
        sc_a = '0;
        val_a = '0;

        // Counter
        if (s_q.run) begin
            if (!s_q.cpwm) begin
                s_d.down = 1'b0;
                if (s_q.cnt == term) begin
                    s_d.cnt = TMC_CNT_ZERO;
                    wrap = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt + TMC_CNT_STEP;
                end
            end else if (!s_q.down) begin
                if (s_q.cnt == term) begin
                    // Turnaround marks end of a center-aligned period
                    s_d.cnt = s_q.cnt - TMC_CNT_STEP;
                    s_d.down = 1'b1;
                    wrap = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt + TMC_CNT_STEP;
                end
            end else if (s_q.cnt == TMC_CNT_ZERO) begin
                s_d.cnt = s_q.cnt + TMC_CNT_STEP;
                s_d.down = 1'b0;
            end else begin
                s_d.cnt = s_q.cnt - TMC_CNT_STEP;
            end
        end
        // A limit caught half way would give a bogus period
        ovf_ev = wrap & ~inhibit;

        // Control and limit readback
        unique case (apb_req.paddr)
            TMC_CTRL_OFS: begin
                rdat[TMC_FLAG_BIT] = s_q.ovf;
                rdat[TMC_IE_BIT] = s_q.ovie;
                rdat[TMC_CPWM_BIT] = s_q.cpwm;
                rdat[TMC_RUN_BIT] = s_q.run;
                err = 1'b0;
            end
            TMC_COUNT_OFS: begin
                rdat[15:0] = s_q.cnt;
                err = 1'b0;
            end
            TMC_LIM_HI_OFS: begin
                rdat[7:0] = s_q.lim[15:8];
                err = 1'b0;
            end
            TMC_LIM_LO_OFS: begin
                rdat[7:0] = s_q.lim[7:0];
                err = 1'b0;
            end
            default: begin
                err = 1'b1;
            end
        endcase

        // Channels
        for (int i = 0; i < NUM_CH; i++) begin
            sc_a = 8'(int'(TMC_CH_BASE) + i * int'(TMC_CH_STRIDE));
            val_a = sc_a + TMC_CH_VAL_OFS;
            // Center select overrides the per-channel mode bits
            if (s_q.cpwm) begin
                mode = TMC_MODE_CPWM;
            end else if (s_q.ch[i].msb) begin
                mode = TMC_MODE_EPWM;
            end else if (s_q.ch[i].msa) begin
                mode = TMC_MODE_OC;
            end else begin
                mode = TMC_MODE_IC;
            end
            rise = ch_in[i] & ~s_q.ch[i].prev;
            fall = ~ch_in[i] & s_q.ch[i].prev;
            match = s_q.run & (s_q.cnt == s_q.ch[i].val);
            s_d.ch[i].prev = ch_in[i];
            // Field 00 frees the pin whatever the mode
            used_v[i] = (mode != TMC_MODE_IC) && (s_q.ch[i].els != TMC_ELS_OFF);
            unique case (mode)
                TMC_MODE_IC: begin
                    // Field bits enable rising and falling edges
                    ev_v[i] = (rise & s_q.ch[i].els[0]) | (fall & s_q.ch[i].els[1]);
                    if (ev_v[i]) begin
                        s_d.ch[i].val = s_q.cnt;
                    end
                end
                TMC_MODE_OC: begin
                    ev_v[i] = match;
                    if (match) begin
                        unique case (s_q.ch[i].els)
                            TMC_ELS_TOGGLE: s_d.ch[i].pin = ~s_q.ch[i].pin;
                            TMC_ELS_CLR: s_d.ch[i].pin = 1'b0;
                            TMC_ELS_SET: s_d.ch[i].pin = 1'b1;
                            TMC_ELS_OFF: s_d.ch[i].pin = s_q.ch[i].pin;
                        endcase
                    end
                end
                TMC_MODE_EPWM: begin
                    // Period start takes the active level; match wins for 0 %
                    if (s_q.cnt == TMC_CNT_ZERO) begin
                        s_d.ch[i].pin = ~s_q.ch[i].els[0];
                    end
                    ev_v[i] = match;
                    if (match) begin
                        s_d.ch[i].pin = s_q.ch[i].els[0];
                    end
                end
                TMC_MODE_CPWM: begin
                    ev_v[i] = match;
                    if (match && !s_q.down) begin
                        s_d.ch[i].pin = s_q.ch[i].els[0];
                    end else if (match) begin
                        s_d.ch[i].pin = ~s_q.ch[i].els[0];
                    end
                end
            endcase
            // Readback of channel words
            if (apb_req.paddr == sc_a) begin
                rdat[TMC_FLAG_BIT] = s_q.ch[i].flag;
                rdat[TMC_IE_BIT] = s_q.ch[i].ie;
                rdat[TMC_MSB_BIT] = s_q.ch[i].msb;
                rdat[TMC_MSA_BIT] = s_q.ch[i].msa;
                rdat[TMC_ELS_HI_BIT:TMC_ELS_LO_BIT] = s_q.ch[i].els;
                err = 1'b0;
            end
            if (apb_req.paddr == val_a) begin
                rdat[15:0] = s_q.ch[i].val;
                err = 1'b0;
            end
            // Arm only if the answer really showed the flag set
            if (rd && apb_req.paddr == sc_a && s_q.ch[i].flag && s_q.rdata[TMC_FLAG_BIT]) begin
                s_d.ch[i].armed = 1'b1;
            end
            if (wr && apb_req.paddr == sc_a) begin
                s_d.ch[i].ie = apb_req.pwdata[TMC_IE_BIT];
                s_d.ch[i].msb = apb_req.pwdata[TMC_MSB_BIT];
                s_d.ch[i].msa = apb_req.pwdata[TMC_MSA_BIT];
                s_d.ch[i].els = apb_req.pwdata[TMC_ELS_HI_BIT:TMC_ELS_LO_BIT];
                // Writing one leaves the flag alone
                if (!apb_req.pwdata[TMC_FLAG_BIT] && s_q.ch[i].armed) begin
                    s_d.ch[i].flag = 1'b0;
                end
                s_d.ch[i].armed = 1'b0;
            end
            if (wr && apb_req.paddr == val_a) begin
                s_d.ch[i].val = apb_req.pwdata[15:0];
            end
            // Set wins over clear; a new event restarts the clear sequence
            if (ev_v[i]) begin
                s_d.ch[i].flag = 1'b1;
                s_d.ch[i].armed = 1'b0;
            end
        end

        // Control word and counter writes
        if (rd && apb_req.paddr == TMC_CTRL_OFS && s_q.ovf && s_q.rdata[TMC_FLAG_BIT]) begin
            s_d.ovf_armed = 1'b1;
        end
        if (wr && apb_req.paddr == TMC_CTRL_OFS) begin
            s_d.run = apb_req.pwdata[TMC_RUN_BIT];
            s_d.ovie = apb_req.pwdata[TMC_IE_BIT];
            s_d.cpwm = apb_req.pwdata[TMC_CPWM_BIT];
            if (!apb_req.pwdata[TMC_FLAG_BIT] && s_q.ovf_armed) begin
                s_d.ovf = 1'b0;
            end
            s_d.ovf_armed = 1'b0;
        end
        // Counter write restarts counting from zero going up
        if (wr && apb_req.paddr == TMC_COUNT_OFS) begin
            s_d.cnt = TMC_CNT_ZERO;
            s_d.down = 1'b0;
        end
        // Byte halves pair up in either order
        if (wr && apb_req.paddr == TMC_LIM_HI_OFS) begin
            s_d.lim[15:8] = apb_req.pwdata[7:0];
            s_d.lim_pend = (s_q.lim_pend == TMC_PEND_LO) ? TMC_PEND_NONE : TMC_PEND_HI;
        end
        if (wr && apb_req.paddr == TMC_LIM_LO_OFS) begin
            s_d.lim[7:0] = apb_req.pwdata[7:0];
            s_d.lim_pend = (s_q.lim_pend == TMC_PEND_HI) ? TMC_PEND_NONE : TMC_PEND_LO;
        end
        if (ovf_ev) begin
            s_d.ovf = 1'b1;
            s_d.ovf_armed = 1'b0;
        end

        // Capture the answer during the wait state
        if (acc && !s_q.ready) begin
            s_d.rdata = rdat;
            s_d.slverr = err;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    // All-zero reset puts limit at zero and clears every flag and enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign prdata = s_q.rdata;
    assign pready = s_q.ready;
    assign pslverr = s_q.ready & s_q.slverr;
    assign ovf_irq = s_q.ovf & s_q.ovie;

    // Per-channel pin and interrupt outputs
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        assign ch_out[g] = s_q.ch[g].pin;
        assign ch_oe_n[g] = ~used_v[g];
        assign ch_irq[g] = s_q.ch[g].flag & s_q.ch[g].ie;
        assign flags_v[g] = s_q.ch[g].flag;
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic cfg_wr;   // Write that moves the counter by software
    assign cfg_wr = wr & (apb_req.paddr == TMC_CTRL_OFS || apb_req.paddr == TMC_COUNT_OFS);

    sequence up_end_s;
        s_q.run && !s_q.cpwm && s_q.cnt == term && !cfg_wr;
    endsequence
    sequence turn_s;
        s_q.run && s_q.cpwm && !s_q.down && s_q.cnt == term && !cfg_wr;
    endsequence

    up_wrap_a: assert property (up_end_s |=> s_q.cnt == TMC_CNT_ZERO)
        else $error("counter did not restart at zero after limit");
    turn_down_a: assert property (turn_s |=> s_q.down && s_q.cnt == $past(s_q.cnt) - 16'h0001)
        else $error("center counter did not turn down at limit");
    ovf_set_a: assert property ((up_end_s or turn_s) ##0 !inhibit |=> s_q.ovf)
        else $error("overflow flag not set at end of period");
    ovf_hold_a: assert property ($rose(s_q.ovf) |-> $past(wrap && !inhibit))
        else $error("overflow flag set while limit half written");
    flag_keep_a: assert property (1 |=> ($past(ev_v) & ~flags_v) == '0)
        else $error("channel event lost");
    irq_track_a: assert property (ch_irq != '0 |-> ##0 ovf_irq == (s_q.ovf & s_q.ovie))
        else $error("interrupt outputs inconsistent");
    pin_free_a: assert property (s_q.cpwm == 1'b0 && s_q.ch[0].els == TMC_ELS_OFF
        |-> ch_oe_n[0])
        else $error("detached pin still driven");
    apb_wait_a: assert property (acc && !pready |=> pready ##1 !pready)
        else $error("APB answer not after exactly one wait state");
    one_keep_a: assert property (wr && apb_req.paddr == TMC_CH_BASE && !s_q.ch[0].flag
        && !ev_v[0] |=> !s_q.ch[0].flag)
        else $error("writing the flag bit set it");

    // Channel 0 stands for every channel: all share one loop body
    sequence ch0_match_s;
        s_q.run && s_q.cnt == s_q.ch[0].val;
    endsequence
    sequence ch0_oc_s;
        !s_q.cpwm && !s_q.ch[0].msb && s_q.ch[0].msa;
    endsequence
    sequence ch0_ep_s;
        !s_q.cpwm && s_q.ch[0].msb;
    endsequence
    sequence ch0_rise_s;
        !s_q.cpwm && !s_q.ch[0].msb && !s_q.ch[0].msa && s_q.ch[0].els[0]
            && ch_in[0] && !s_q.ch[0].prev;
    endsequence
    // A value write in the same cycle overrides the captured count
    sequence ch0_cap_s;
        !s_q.cpwm && !s_q.ch[0].msb && !s_q.ch[0].msa && ev_v[0]
            && !(wr && apb_req.paddr == TMC_CH_BASE + TMC_CH_VAL_OFS);
    endsequence

    cap_rise_a: assert property (ch0_rise_s |=> s_q.ch[0].flag)
        else $error("rising capture edge did not set the channel flag");
    cap_latch_a: assert property (ch0_cap_s |=> s_q.ch[0].val == $past(s_q.cnt))
        else $error("capture did not latch the counter");
    oc_flag_a: assert property (ch0_oc_s ##0 ch0_match_s |=> s_q.ch[0].flag)
        else $error("compare match did not set the channel flag");
    cpwm_flag_a: assert property (s_q.cpwm ##0 ch0_match_s |=> s_q.ch[0].flag)
        else $error("center match did not set the channel flag");
    epwm_match_a: assert property (ch0_ep_s ##0 ch0_match_s
        |=> ch_out[0] == $past(s_q.ch[0].els[0]))
        else $error("edge PWM match did not end the pulse");
    cpwm_up_a: assert property ((s_q.cpwm && !s_q.down) ##0 ch0_match_s
        |=> ch_out[0] == $past(s_q.ch[0].els[0]))
        else $error("center up-count match gave the wrong level");
    cpwm_down_a: assert property ((s_q.cpwm && s_q.down) ##0 ch0_match_s
        |=> ch_out[0] != $past(s_q.ch[0].els[0]))
        else $error("center down-count match gave the wrong level");
    lim_pend_a: assert property (wr && apb_req.paddr == TMC_LIM_HI_OFS
        && s_q.lim_pend == TMC_PEND_NONE |=> inhibit)
        else $error("half-written limit did not hold off the overflow flag");

endmodule  // tmc_timer

// ---- test/tmc_pin_model.sv ----
// Behavioural model of the signals that face the timer channel pins.
// Assumes the bench sets the outside level that each undriven pin sees.
`timescale 1ns/1ns
module tmc_pin_model #(
    parameter int NUM_CH = 2  // Number of channel pins
) (
    input wire logic [NUM_CH-1:0] ch_out,   // Block drive level
    input wire logic [NUM_CH-1:0] ch_oe_n,  // Block drive enable, low drives
    input wire logic [NUM_CH-1:0] ext_lvl,  // Level from the outside source
    output logic [NUM_CH-1:0] pin_lvl       // Resolved pin level
);
    // ************************************************************
    // Pin resolution
    // ************************************************************
    // The block wins while it drives, so a detached pin shows the outside level
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            pin_lvl[i] = ch_oe_n[i] ? ext_lvl[i] : ch_out[i];
        end
    end
endmodule  // tmc_pin_model

// ---- test/tmc_timer_tb_top.sv ----
// Self-checking bench of the timer block: APB tasks and register sequences.
// Assumes a 20 MHz pclk and the pin model on the channel pins.
`timescale 1ns/1ns
module tmc_timer_tb_top;
    import tmc_pkg::*;
    logic pclk;  // Bus clock
    logic presetn;  // Reset, active low
    tmc_apb_req_t req;  // APB request
    logic [31:0] prdata;  // Read data
    logic pready;  // Ready
    logic pslverr;  // Error
    logic [1:0] ch_in, ch_out, ch_oe_n, ch_irq, ext_lvl;  // Channel pins
    logic ovf_irq;  // Overflow request
    int n_errors = 0;  // Mismatches
    int n_tests = 0;  // Comparisons
    logic [31:0] rd;  // Last read word
    logic err;  // Last error response
    // ************************************************************
    // Design and far side
    // ************************************************************
    tmc_timer #(.NUM_CH(2)) dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch_in(ch_in),
        .ch_out(ch_out), .ch_oe_n(ch_oe_n), .ch_irq(ch_irq), .ovf_irq(ovf_irq));
    tmc_pin_model #(.NUM_CH(2)) pins (.ch_out(ch_out), .ch_oe_n(ch_oe_n),
        .ext_lvl(ext_lvl), .pin_lvl(ch_in));
    // ************************************************************
    // Tasks
    // ************************************************************
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits for pready, never for a fixed count
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    // Verdict, reached by the sequence or by the watchdog
    task automatic end_of_test();
        $display("errors=%0d tests=%0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ************************************************************
    // Clock, watchdog and sequence
    // ************************************************************
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // Whole sequence needs well under 2000 cycles
    initial begin
        #(50 * 5000);
        n_errors++;
        end_of_test();
    end
    initial begin
        presetn = 1'b0;
        req = '0;
        ext_lvl = 2'b00;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, TMC_LIM_HI_OFS, 32'h0); chk(rd, 32'h0);
        apb(1'b0, TMC_LIM_LO_OFS, 32'h0); chk(rd, 32'h0);
        apb(1'b0, TMC_CH_BASE, 32'h0); chk(rd, 32'h0);
        chk({30'h0, ch_oe_n}, 32'h3);
        // Limit set while stopped and counter cleared, so the first wrap is known
        apb(1'b1, TMC_LIM_LO_OFS, 32'h40);
        apb(1'b1, TMC_LIM_HI_OFS, 32'h00);
        apb(1'b1, TMC_COUNT_OFS, 32'h0);
        apb(1'b1, TMC_CH_BASE + TMC_CH_VAL_OFS, 32'h20);
        apb(1'b1, TMC_CH_BASE, 32'h54);  // Compare, toggle, irq enabled
        apb(1'b1, TMC_CH_BASE + TMC_CH_STRIDE, 32'h04);  // Capture on rising edge
        chk({30'h0, ch_oe_n}, 32'h2);
        apb(1'b1, TMC_CTRL_OFS, 32'h01);
        repeat (40) @(posedge pclk);
        chk({30'h0, ch_out}, 32'h1);
        repeat (60) @(posedge pclk);
        chk({30'h0, ch_out}, 32'h0);
        chk({30'h0, ch_irq}, 32'h1);
        chk({31'h0, ovf_irq}, 32'h0);
        apb(1'b0, TMC_CTRL_OFS, 32'h0); chk(rd, 32'h81);
        apb(1'b1, TMC_CTRL_OFS, 32'h00);  // Stop and clear overflow flag
        apb(1'b0, TMC_CTRL_OFS, 32'h0); chk(rd, 32'h00);
        apb(1'b0, TMC_CH_BASE, 32'h0); chk(rd, 32'hD4);
        apb(1'b1, TMC_CH_BASE, 32'h54);
        apb(1'b0, TMC_CH_BASE, 32'h0); chk(rd, 32'h54);
        chk({30'h0, ch_irq}, 32'h0);
        apb(1'b1, TMC_CH_BASE, 32'hD4);
        apb(1'b0, TMC_CH_BASE, 32'h0); chk(rd, 32'h54);
        // Rising edge on the capture pin sets its flag
        @(posedge pclk);
        ext_lvl <= 2'b10;
        repeat (4) @(posedge pclk);
        apb(1'b0, TMC_CH_BASE + TMC_CH_STRIDE, 32'h0); chk(rd, 32'h84);
        // Counter stopped at 0x2B, so the capture holds that count
        apb(1'b0, TMC_CH_BASE + TMC_CH_STRIDE + TMC_CH_VAL_OFS, 32'h0);
        chk(rd, 32'h2B);
        // Center mode with only the high limit byte written: turnaround must not flag
        apb(1'b1, TMC_COUNT_OFS, 32'h0);
        apb(1'b1, TMC_LIM_HI_OFS, 32'h00);
        apb(1'b1, TMC_CTRL_OFS, 32'h61);
        repeat (100) @(posedge pclk);
        apb(1'b0, TMC_CTRL_OFS, 32'h0);
        chk(rd, 32'h61);
        apb(1'b1, TMC_LIM_LO_OFS, 32'h10);
        repeat (60) @(posedge pclk);
        chk({31'h0, ovf_irq}, 32'h1);
        chk({30'h0, ch_oe_n}, 32'h0);
        // Edge PWM, high-true: active from count zero until the match at 8
        apb(1'b1, TMC_CTRL_OFS, 32'h00);
        apb(1'b1, TMC_COUNT_OFS, 32'h0);
        apb(1'b1, TMC_CH_BASE + TMC_CH_VAL_OFS, 32'h08);
        apb(1'b1, TMC_CH_BASE, 32'h28);
        apb(1'b1, TMC_CTRL_OFS, 32'h01);
        repeat (4) @(posedge pclk);
        chk({31'h0, ch_out[0]}, 32'h1);
        repeat (9) @(posedge pclk);
        chk({31'h0, ch_out[0]}, 32'h0);
        apb(1'b0, 8'hFC, 32'h0); chk({31'h0, err}, 32'h1);
        end_of_test();
    end
endmodule  // tmc_timer_tb_top
